// >>> hdl/rsm_pkg.sv
// Package: constants and types for the reset sequencer and supply monitor
package rsm_pkg;

   // ****************************************
   // Register map (integrity_ctrl_status)
   // ****************************************
   localparam logic [1:0] ADDR_INTEGRITY_CTRL_STATUS = 2'h0;
   localparam logic [1:0] ADDR_OPTION_STATUS = 2'h1;
   localparam int BIT_AUX_INPUT_SELECT = 7;
   localparam int BIT_AUX_DETECT_IRQ_ENABLE = 6;
   localparam int BIT_AUX_DETECT_FLAG = 5;
   localparam int BIT_LOWVOLT_RESET_FLAG = 4;
   localparam int BIT_WATCHDOG_RESET_FLAG = 0;
   localparam logic [7:0] INTEGRITY_RESET_VALUE = 8'h00;

   // ****************************************
   // Timing
   // ****************************************
   localparam int DELAY_SHORT_CYCLES = 256;
   localparam int DELAY_LONG_CYCLES = 4096;
   localparam int FETCH_CYCLES = 2;
   // Minimum output reset width in ns, and its count at 40 MHz (round up)
   localparam int CLK_PERIOD_NS = 25;
   localparam int RESET_OUT_MIN_WIDTH_NS = 20000;
   localparam int RESET_OUT_MIN_CYCLES =
      (RESET_OUT_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 13;

   // ****************************************
   // Reset vector
   // ****************************************
   localparam logic [15:0] RESET_VECTOR_LO = 16'hfffe;
   localparam logic [15:0] RESET_VECTOR_HI = 16'hffff;

   // ****************************************
   // Option encodings
   // ****************************************
   typedef enum logic [2:0] {
      CLK_SRC_EXTERNAL = 3'h0,
      CLK_SRC_XTAL_R0 = 3'h1,
      CLK_SRC_XTAL_R1 = 3'h2,
      CLK_SRC_XTAL_R2 = 3'h3,
      CLK_SRC_XTAL_R3 = 3'h4,
      CLK_SRC_RC = 3'h5
   } clk_src_t;

   typedef enum logic [1:0] {
      LVD_THR_LOW = 2'h0,
      LVD_THR_MEDIUM = 2'h1,
      LVD_THR_HIGH = 2'h2
   } lvd_thr_t;

   typedef struct packed {
      logic lvd_enable;
      lvd_thr_t lvd_threshold;
      logic long_delay;
      clk_src_t clk_source;
   } option_t;

   typedef enum logic [3:0] {
      ST_ACTIVE = 4'b0001,
      ST_DELAY = 4'b0010,
      ST_FETCH = 4'b0100,
      ST_RUN = 4'b1000
   } seq_state_t;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      seq_state_t state;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] pin_cnt;
      logic pin_low;
      logic pin_mask;
      logic cpu_reset;
      logic fetch_lo;
      logic [15:0] fetch_addr;
      logic fetch_valid;
      logic aux_input_select;
      logic aux_detect_irq_enable;
      logic aux_flag;
      logic aux_irq;
      logic lowvolt_reset_flag;
      logic watchdog_reset_flag;
      logic [2:0] pin_sync;
      logic [2:0] lvd_sync;
      logic [2:0] avd_sync;
      logic [2:0] evd_sync;
      logic pin_stable;
      logic [7:0] rdata;
      logic xtal_run;
      logic [2:0] osc_sel;
      logic [1:0] lvd_thr;
   } rsm_state_t;

endpackage

// >>> hdl/reset_sequencer.sv
// Reset sequencer with supply monitor flags and integrity register
// Function
// RULE1: Three reset causes: external pin low, low-voltage detector, watchdog.
// RULE2: Reset pin is driven low during the whole delay phase.
// RULE3: Each reset runs active phase, then delay, then vector fetch.
// RULE4: Delay is 256 or 4096 cycles, chosen by option setting; the code also holds the delay until the minimum output width count has run out.
// RULE5: Vector fetch phase takes exactly two clock cycles.
// RULE6: Start address is fetched from the top two bytes of memory.
// RULE7: Crystal oscillators keep running while reset is asserted.
// RULE8: Option setting selects external, four crystal ranges or RC clock.
// RULE9: External reset is detected asynchronously, without a running clock.
// RULE10: A recognised external pulse makes the device drive the pin low.
// RULE11: Watchdog underflow drives pin low for at least minimum output width.
// RULE12: Pin held low while the low-voltage detector holds reset.
// RULE13: Low-voltage reset is static below threshold, with hysteresis.
// RULE14: Option setting picks low, medium or high detector threshold.
// RULE15: Option setting enables the detector; disabled means no reset.
// RULE16: Auxiliary comparator output is a read-only real-time flag.
// RULE17: Auxiliary detector works only when the low-voltage detector is on.
// RULE18: Select bit chooses main supply (0) or external input pin (1).
// RULE19: With enable set, every flag change raises an interrupt request; the code raises none when the flag clears because the detector is disabled.
// RULE20: Cause flags: low-voltage sets its flag, clears watchdog; write zero clears.
// RULE21: Delay restarts while any cause is active; counts after all removed.
//
// The register addresses and the plain strobed port were decided locally.
module reset_sequencer
   import rsm_pkg::*;
#(
   parameter int DELAY_LONG = DELAY_LONG_CYCLES,
   parameter int DELAY_SHORT = DELAY_SHORT_CYCLES,
   parameter int OUT_MIN = RESET_OUT_MIN_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire option_t option_i,
   input wire logic reset_pin_i,
   output logic reset_pin_o,
   output logic reset_pin_oe_o,
   input wire logic lvd_below_i,
   input wire logic avd_supply_below_i,
   input wire logic avd_evd_below_i,
   input wire logic watchdog_underflow_i,
   input wire reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   output logic cpu_reset_o,
   output logic [15:0] fetch_addr_o,
   output logic fetch_valid_o,
   output logic aux_irq_o,
   output logic xtal_run_o,
   output logic [2:0] osc_select_o,
   output logic [1:0] lvd_threshold_o
);

   // ****************************************
   // Reset release and asynchronous pin capture
   // ****************************************
   logic [1:0] rst_sync_q;
   logic sys_rst_n;
   logic pin_latched_q;
   logic pin_clr;
   logic pin_ext_n;

   // Release the reset through two flops
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign sys_rst_n = rst_sync_q[1];

   // Low level on the pin latches without a clock, even when halted;
   // our own drive is masked so it cannot hold the sequence in reset
   always_ff @(posedge core_clk_i or negedge sys_rst_n or negedge pin_ext_n) begin
      if (!sys_rst_n) begin
         pin_latched_q <= 1'b0;
      end else if (!pin_ext_n) begin
         pin_latched_q <= 1'b1; // see RULE9
      end else if (pin_clr) begin
         pin_latched_q <= 1'b0;
      end
   end

   rsm_state_t s_q, s_d;

   // Pin seen through a mask that covers our drive and one cycle after it,
   // so releasing the wire cannot glitch the latch
   assign pin_ext_n = reset_pin_i || s_q.pin_mask;
   logic ext_cause;
   logic lvd_cause;
   logic wdg_cause;
   logic any_cause;
   logic avd_raw;
   logic [CNT_W-1:0] delay_len;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      s_d = s_q;
      pin_clr = 1'b0;
      // Three-flop sampling of outside levels
      s_d.pin_sync = {s_q.pin_sync[1:0], pin_ext_n};
      s_d.lvd_sync = {s_q.lvd_sync[1:0], lvd_below_i};
      s_d.avd_sync = {s_q.avd_sync[1:0], avd_supply_below_i};
      s_d.evd_sync = {s_q.evd_sync[1:0], avd_evd_below_i};
      if (s_q.pin_sync[2] == s_q.pin_sync[1]) begin
         s_d.pin_stable = s_q.pin_sync[1];
      end
      // Cause qualification
      ext_cause = pin_latched_q; // see RULE1
      // Comparator carries hysteresis; static while below
      lvd_cause = option_i.lvd_enable && (s_q.lvd_sync[2] == s_q.lvd_sync[1])
                  && s_q.lvd_sync[1]; // see RULE13, RULE15
      wdg_cause = watchdog_underflow_i; // see RULE1
      any_cause = ext_cause || lvd_cause || wdg_cause;
      // Clear the latch once the masked pin reads high; the cause is taken that edge
      if (pin_latched_q && s_q.pin_stable) begin
         pin_clr = 1'b1;
      end
      // Option-selected delay length
      delay_len = option_i.long_delay ? CNT_W'(DELAY_LONG) : CNT_W'(DELAY_SHORT); // see RULE4

      // Pin width counter guarantees the minimum output pulse
      if (s_q.pin_cnt != '0) begin
         s_d.pin_cnt = s_q.pin_cnt - CNT_W'(1);
      end

      s_d.fetch_valid = 1'b0;
      case (s_q.state)
         ST_RUN: begin
            if (any_cause) begin
               s_d.state = ST_ACTIVE; // see RULE3
               s_d.cpu_reset = 1'b1;
               s_d.pin_low = 1'b1; // see RULE10, RULE11, RULE12
               s_d.pin_cnt = CNT_W'(OUT_MIN); // see RULE11
            end
         end
         ST_ACTIVE: begin
            s_d.pin_low = 1'b1;
            if (!any_cause) begin
               s_d.state = ST_DELAY;
               s_d.cnt = delay_len - CNT_W'(1);
            end
         end
         ST_DELAY: begin
            s_d.pin_low = 1'b1; // see RULE2
            if (any_cause) begin
               s_d.cnt = delay_len - CNT_W'(1); // see RULE21
            end else if (s_q.cnt == '0 && s_q.pin_cnt == '0) begin
               s_d.state = ST_FETCH;
               s_d.pin_low = 1'b0;
               s_d.fetch_lo = 1'b1;
            end else if (s_q.cnt != '0) begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end
         end
         ST_FETCH: begin
            // Two cycles: low byte then high byte of vector
            s_d.fetch_valid = 1'b1; // see RULE5
            s_d.fetch_addr = s_q.fetch_lo ? RESET_VECTOR_LO : RESET_VECTOR_HI; // see RULE6
            s_d.fetch_lo = 1'b0;
            if (any_cause) begin
               s_d.state = ST_ACTIVE;
               s_d.pin_low = 1'b1;
               s_d.fetch_valid = 1'b0;
               s_d.pin_cnt = CNT_W'(OUT_MIN);
            end else if (!s_q.fetch_lo) begin
               s_d.state = ST_RUN;
               s_d.cpu_reset = 1'b0;
            end
         end
         default: begin
            s_d.state = ST_ACTIVE;
         end
      endcase
      // Mask stays up one cycle past the drive
      s_d.pin_mask = s_d.pin_low || s_q.pin_low;

      // Reset cause flags; hardware set wins over software clear
      if (reg_req_i.wr && reg_req_i.addr == ADDR_INTEGRITY_CTRL_STATUS) begin
         s_d.aux_input_select = reg_req_i.wdata[BIT_AUX_INPUT_SELECT]; // see RULE18
         s_d.aux_detect_irq_enable = reg_req_i.wdata[BIT_AUX_DETECT_IRQ_ENABLE];
         if (!reg_req_i.wdata[BIT_LOWVOLT_RESET_FLAG]) begin
            s_d.lowvolt_reset_flag = 1'b0; // see RULE20
         end
         if (!reg_req_i.wdata[BIT_WATCHDOG_RESET_FLAG]) begin
            s_d.watchdog_reset_flag = 1'b0;
         end
      end
      if (lvd_cause) begin
         s_d.lowvolt_reset_flag = 1'b1; // see RULE20
         s_d.watchdog_reset_flag = 1'b0;
      end else if (wdg_cause) begin
         s_d.watchdog_reset_flag = 1'b1; // see RULE20
      end

      // Auxiliary flag follows comparator, only with detector enabled
      avd_raw = s_q.aux_input_select ? s_q.evd_sync[2] : s_q.avd_sync[2];
      // A level change counts once the second and third flops agree
      if (s_q.aux_input_select ? (s_q.evd_sync[2] == s_q.evd_sync[1])
                               : (s_q.avd_sync[2] == s_q.avd_sync[1])) begin
         s_d.aux_flag = option_i.lvd_enable && avd_raw; // see RULE16, RULE17
      end else begin
         s_d.aux_flag = option_i.lvd_enable && s_q.aux_flag;
      end
      s_d.aux_irq = s_q.aux_detect_irq_enable && option_i.lvd_enable
                    && (s_d.aux_flag != s_q.aux_flag); // see RULE19

      // Read data, valid the cycle after the strobe
      s_d.rdata = 8'h00;
      if (reg_req_i.rd) begin
         if (reg_req_i.addr == ADDR_INTEGRITY_CTRL_STATUS) begin
            s_d.rdata[BIT_AUX_INPUT_SELECT] = s_q.aux_input_select;
            s_d.rdata[BIT_AUX_DETECT_IRQ_ENABLE] = s_q.aux_detect_irq_enable;
            s_d.rdata[BIT_AUX_DETECT_FLAG] = s_q.aux_flag; // see RULE16
            s_d.rdata[BIT_LOWVOLT_RESET_FLAG] = s_q.lowvolt_reset_flag;
            s_d.rdata[BIT_WATCHDOG_RESET_FLAG] = s_q.watchdog_reset_flag;
         end else if (reg_req_i.addr == ADDR_OPTION_STATUS) begin
            s_d.rdata = {option_i.lvd_enable, option_i.lvd_threshold,
                         option_i.long_delay, 1'b0, option_i.clk_source};
         end else begin
            s_d.rdata = 8'h00;
         end
      end

      // Clock source and threshold follow the option setting
      s_d.osc_sel = option_i.clk_source; // see RULE8
      s_d.lvd_thr = option_i.lvd_threshold; // see RULE14
      // Crystal kept running through reset when selected
      s_d.xtal_run = (option_i.clk_source != CLK_SRC_EXTERNAL)
                     && (option_i.clk_source != CLK_SRC_RC); // see RULE7
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge core_clk_i or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         s_q <= '{state: ST_ACTIVE, cnt: '0, pin_cnt: '0, pin_low: 1'b1, pin_mask: 1'b1,
                  cpu_reset: 1'b1, fetch_lo: 1'b0, fetch_addr: 16'h0000,
                  fetch_valid: 1'b0, aux_input_select: 1'b0,
                  aux_detect_irq_enable: 1'b0, aux_flag: 1'b0, aux_irq: 1'b0,
                  lowvolt_reset_flag: 1'b0, watchdog_reset_flag: 1'b0,
                  pin_sync: 3'h7, lvd_sync: 3'h0, avd_sync: 3'h0,
                  evd_sync: 3'h0, pin_stable: 1'b1, rdata: 8'h00,
                  xtal_run: 1'b1, osc_sel: 3'h0, lvd_thr: 2'h0};
      end else if (clk_en_i) begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reset_pin_o = 1'b0;
   assign reset_pin_oe_o = s_q.pin_low; // see RULE2
   assign reg_rdata_o = s_q.rdata;
   assign cpu_reset_o = s_q.cpu_reset;
   assign fetch_addr_o = s_q.fetch_addr;
   assign fetch_valid_o = s_q.fetch_valid;
   assign aux_irq_o = s_q.aux_irq;
   assign xtal_run_o = s_q.xtal_run;
   assign osc_select_o = s_q.osc_sel;
   assign lvd_threshold_o = s_q.lvd_thr;

endmodule

// >>> verif/seq_monitor.sv
// Checker for the reset sequencer port behaviour
module seq_monitor
   import rsm_pkg::*;
#(
   parameter int DELAY_LONG = 16,
   parameter int DELAY_SHORT = 4
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire option_t option_i,
   input wire logic reset_pin_i,
   input wire logic reset_pin_oe_o,
   input wire logic lvd_below_i,
   input wire logic watchdog_underflow_i,
   input wire reg_req_t reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic cpu_reset_o,
   input wire logic [15:0] fetch_addr_o,
   input wire logic fetch_valid_o,
   input wire logic aux_irq_o,
   input wire logic xtal_run_o,
   input wire logic [2:0] osc_select_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ******
   // Helper count and properties
   // ******
   int low_q;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Cycles the device has been driving the reset wire low
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         low_q <= 0;
      end else begin
         low_q <= reset_pin_oe_o ? low_q + 1 : 0;
      end
   end
   a_fetch_order: assert property (
      fetch_valid_o && fetch_addr_o == 16'hfffe |=> fetch_valid_o
      && fetch_addr_o == 16'hffff ##1 !cpu_reset_o) else $error("bad vector fetch");
   a_pin_delay: assert property (
      $fell(reset_pin_oe_o) |=> fetch_valid_o && fetch_addr_o == 16'hfffe)
      else $error("pin released outside fetch");
   a_delay_len: assert property (
      $fell(reset_pin_oe_o) |-> low_q >= (option_i.long_delay ? DELAY_LONG : DELAY_SHORT))
      else $error("delay too short");
   a_wdog_pull: assert property (
      watchdog_underflow_i && !cpu_reset_o |=> reset_pin_oe_o && cpu_reset_o)
      else $error("watchdog cause ignored");
   a_out_width: assert property (
      $rose(reset_pin_oe_o) |-> reset_pin_oe_o [*4]) else $error("pin pulse too short");
   a_ext_pull: assert property (
      !reset_pin_i && !reset_pin_oe_o |-> ##[1:6] reset_pin_oe_o)
      else $error("external reset not driven");
   a_lvd_pull: assert property (
      (option_i.lvd_enable && lvd_below_i) [*8] |-> reset_pin_oe_o)
      else $error("low supply not holding pin");
   a_read_idle: assert property (
      !$past(reg_req_i.rd) |-> reg_rdata_o == 8'h00) else $error("stray read data");
   a_irq_pulse: assert property (
      aux_irq_o |=> !aux_irq_o) else $error("irq longer than a cycle");
   a_xtal_run: assert property (
      osc_select_o inside {[3'h1:3'h4]} |-> xtal_run_o) else $error("crystal stopped");
endmodule

bind reset_sequencer seq_monitor #(.DELAY_LONG(DELAY_LONG), .DELAY_SHORT(DELAY_SHORT)) mon (
   .core_clk_i, .reset_n_i, .option_i, .reset_pin_i, .reset_pin_oe_o, .lvd_below_i,
   .watchdog_underflow_i, .reg_req_i, .reg_rdata_o, .cpu_reset_o, .fetch_addr_o,
   .fetch_valid_o, .aux_irq_o, .xtal_run_o, .osc_select_o);

// >>> verif/reset_line_model.sv
// External reset circuitry sharing the open-drain reset wire
module reset_line_model (
   input wire logic pull_low_i,
   input wire logic dev_oe_i,
   output logic line_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Wired low with pull-up: a released wire idles high
   assign line_o = !(pull_low_i || dev_oe_i);
endmodule

// >>> verif/test_reset_sequencer.sv
// Self-checking bench for the reset sequencer
module test_reset_sequencer
   import rsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ******
   // Stimulus, partner and design
   // ******
   logic clk = 0, rst_n = 0, ext = 0, low_voltage_detector = 0, avd_s = 0, avd_e = 0, wdog = 0;
   logic en = 1'b1;
   logic pin, oe, cpu_rst, fv, irq, xtal;
   logic [15:0] faddr;
   logic [7:0] rdata;
   logic [2:0] osel;
   logic [1:0] thr;
   option_t opt = '{1'b1, LVD_THR_HIGH, 1'b0, CLK_SRC_XTAL_R0};
   reg_req_t req = '0;
   int bad_count = 0, compares = 0, irq_n = 0, base;
   reset_line_model partner (.pull_low_i(ext), .dev_oe_i(oe), .line_o(pin));
   reset_sequencer #(.DELAY_LONG(16), .DELAY_SHORT(4), .OUT_MIN(4)) uut (
      .core_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(en), .option_i(opt),
      .reset_pin_i(pin), .reset_pin_o(), .reset_pin_oe_o(oe), .lvd_below_i(low_voltage_detector),
      .avd_supply_below_i(avd_s), .avd_evd_below_i(avd_e), .watchdog_underflow_i(wdog),
      .reg_req_i(req), .reg_rdata_o(rdata), .cpu_reset_o(cpu_rst), .fetch_addr_o(faddr),
      .fetch_valid_o(fv), .aux_irq_o(irq), .xtal_run_o(xtal), .osc_select_o(osel),
      .lvd_threshold_o(thr));
   // Clock, interrupt pulse count and hang guard
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) irq_n <= irq_n + 32'(irq);
   initial begin
      #200us;
      bad_count++;
      tally_and_finish();
   end
   function automatic logic [7:0] stat(option_t o);
      return {o.lvd_enable, o.lvd_threshold, o.long_delay, 1'b0, o.clk_source};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) req <= '0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) req <= '0;
      #1 chk(16'(rdata), 16'(exp));
   endtask
   // Follow the pin release, then the two vector fetch cycles
   task automatic seq(input int dly);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (oe && n < 9000);
      chk(16'(n >= dly - 3 && n <= dly + 8), 16'h1);
      tick(1); // First vector byte shows one cycle after release
      chk(faddr & {16{fv}}, 16'hfffe);
      tick(1);
      chk(faddr & {16{fv}}, 16'hffff);
      tick(1);
      chk(16'(cpu_rst), 16'h0);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ******
   // Scenarios
   // ******
   initial begin
      void'($urandom(32'hf5bcbd3b));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      seq(4);
      rd(2'h0, 8'h00);
      // Watchdog cause with the long delay
      @(posedge clk);
      opt.long_delay <= 1'b1;
      wdog <= 1'b1;
      @(posedge clk) wdog <= 1'b0;
      #1 chk(16'(oe & cpu_rst), 16'h1);
      seq(16);
      rd(2'h0, 8'h01);
      // Supply drop holds reset, then clears the watchdog flag
      @(posedge clk) low_voltage_detector <= 1'b1;
      tick(12 + $urandom % 8);
      chk(16'(oe), 16'h1);
      @(posedge clk) low_voltage_detector <= 1'b0;
      seq(16);
      rd(2'h0, 8'h10);
      wr(2'h0, 8'h00);
      rd(2'h0, 8'h00);
      // Short pulse from the far side is stretched
      @(posedge clk) ext <= 1'b1;
      repeat (3) @(posedge clk);
      ext <= 1'b0;
      tick(2);
      chk(16'(oe), 16'h1);
      seq(16);
      rd(2'h0, 8'h00);
      // Detector disabled: no reset and no aux flag
      @(posedge clk);
      opt.lvd_enable <= 1'b0;
      low_voltage_detector <= 1'b1;
      avd_s <= 1'b1;
      tick(20);
      chk(16'(cpu_rst | oe), 16'h0);
      rd(2'h0, 8'h00);
      @(posedge clk);
      low_voltage_detector <= 1'b0;
      avd_s <= 1'b0;
      tick(6);
      @(posedge clk) opt.lvd_enable <= 1'b1;
      // Aux flag on supply, then on the external input
      wr(2'h0, 8'h40);
      tick(6);
      base = irq_n;
      @(posedge clk) avd_s <= 1'b1;
      tick(8);
      rd(2'h0, 8'h60);
      @(posedge clk) avd_s <= 1'b0;
      tick(8);
      chk(16'(irq_n - base), 16'h2);
      wr(2'h0, 8'h80);
      @(posedge clk) avd_e <= 1'b1;
      tick(8);
      rd(2'h0, 8'ha0);
      chk(16'(irq_n - base), 16'h2);
      @(posedge clk) avd_e <= 1'b0;
      // Unmapped write, read-only flag bit, unmapped read
      wr(2'h3, 8'hff);
      wr(2'h0, 8'h20);
      rd(2'h2, 8'h00);
      rd(2'h0, 8'h00);
      // Random option settings
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         opt.clk_source <= clk_src_t'($urandom % 6);
         opt.lvd_threshold <= lvd_thr_t'($urandom % 3);
         tick(3);
         chk({xtal, thr, osel}, {opt.clk_source inside {[1:4]}, opt.lvd_threshold,
             opt.clk_source});
         rd(2'h1, stat(opt));
      end
      // Write while the clock enable is low is lost
      @(posedge clk) en <= 1'b0;
      wr(2'h0, 8'hc0);
      @(posedge clk) en <= 1'b1;
      rd(2'h0, 8'h00);
      tally_and_finish();
   end
endmodule
